//--- issf_slave.sv
// I2C slave port: bus state, buffer handshake and status flags.
// Assumes SCL and SDA are open-drain pins from another domain and a
// register port on clock_i with read data one cycle after the strobe.
`include "issf_regs.svh"
module issf_slave
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Byte event towards the CPU interrupt logic
  output logic            byte_event_o,
  // I2C pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o
);
  import issf_pkg::*;

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_q;
    logic        sda_q;
    issf_phase_t phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        addr_phase;
    logic        nack_out;
    logic [7:0]  data_buffer;
    logic [7:0]  tx_shift;
    logic [1:0]  load_cnt;
    logic [6:0]  slave_addr;
    logic        start_seen;
    logic        stop_seen;
    logic        rw_flag;
    logic        addr_data_flag;
    logic        buf_full;
    logic        nack_flag;
    logic        write_collision;
    logic        rx_overrun;
    logic        scl_release;
    logic        read_stretch_en;
    logic        hold_scl;
    logic        event_p;
    logic [7:0]  rdata;
  } issf_state_t;

  issf_state_t st;
  issf_state_t next_st;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic buf_wr_ok;

  function automatic logic [7:0] issf_status(input issf_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`ISSF_BIT_START] = s.start_seen;
    v[`ISSF_BIT_STOP]  = s.stop_seen;
    v[`ISSF_BIT_RW]    = s.rw_flag;
    v[`ISSF_BIT_AD]    = s.addr_data_flag;
    v[`ISSF_BIT_BF]    = s.buf_full;
    v[`ISSF_BIT_NACK]  = s.nack_flag;
    v[`ISSF_BIT_WCOL]  = s.write_collision;
    v[`ISSF_BIT_ROVR]  = s.rx_overrun;
    return v;
  endfunction

  // Edges use only the second synchroniser stage and its delayed copy
  assign scl_rise   = st.scl_sync[1] & ~st.scl_q;
  assign scl_fall   = ~st.scl_sync[1] & st.scl_q;
  assign start_cond = st.scl_sync[1] & st.scl_q & st.sda_q & ~st.sda_sync[1];
  assign stop_cond  = st.scl_sync[1] & st.scl_q & ~st.sda_q & st.sda_sync[1];
  assign buf_wr_ok  = st.rw_flag & st.read_stretch_en & ~st.scl_release;

  always_comb
  begin
    next_st = st;
    next_st.event_p = 1'b0;
    next_st.scl_sync = {st.scl_sync[0], scl_i};
    next_st.sda_sync = {st.sda_sync[0], sda_i};
    next_st.scl_q = st.scl_sync[1];
    next_st.sda_q = st.sda_sync[1];

    // Register port
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `ISSF_ADDR_STATUS:  next_st.rdata = issf_status(st);
        `ISSF_ADDR_BUFFER:  next_st.rdata = st.data_buffer;
        `ISSF_ADDR_CONTROL: next_st.rdata = {6'h00, st.read_stretch_en,
                                             st.scl_release};
        default:            next_st.rdata = {1'b0, st.slave_addr};
      endcase
      if (reg_addr_i == `ISSF_ADDR_BUFFER && !st.rw_flag)
        next_st.buf_full = 1'b0;
    end
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `ISSF_ADDR_STATUS:
        begin
          if (!reg_wdata_i[`ISSF_BIT_WCOL])
            next_st.write_collision = 1'b0;
          if (!reg_wdata_i[`ISSF_BIT_ROVR])
            next_st.rx_overrun = 1'b0;
        end
        `ISSF_ADDR_BUFFER:
        begin
          // guarded; a held clock is no transfer
          if (buf_wr_ok && !(st.phase == ISSF_TX && !st.hold_scl))
          begin
            next_st.data_buffer = reg_wdata_i;
            next_st.buf_full = 1'b1;
          end
          else
            next_st.write_collision = 1'b1;
        end
        `ISSF_ADDR_CONTROL:
        begin
          next_st.scl_release = reg_wdata_i[`ISSF_CTL_RELEASE];
          next_st.read_stretch_en = reg_wdata_i[`ISSF_CTL_STRETCH];
        end
        default: next_st.slave_addr = reg_wdata_i[6:0];
      endcase
    end

    if (st.load_cnt != 2'h0)
    begin
      next_st.load_cnt = st.load_cnt - 2'h1;
      if (st.load_cnt == 2'h1)
      begin
        next_st.tx_shift = st.data_buffer;
        next_st.buf_full = 1'b1;
      end
    end
    // release after software sets the bit
    if (st.hold_scl && st.scl_release)
    begin
      next_st.hold_scl = 1'b0;
      next_st.tx_shift = st.data_buffer;
      next_st.scl_release = 1'b0;
    end

    if (start_cond)
    begin
      next_st.start_seen = 1'b1;
      next_st.stop_seen = 1'b0;
      next_st.nack_flag = 1'b0;
      next_st.rw_flag = 1'b0;
      next_st.phase = ISSF_RX;
      next_st.addr_phase = 1'b1;
      next_st.bit_cnt = 4'h0;
      next_st.hold_scl = 1'b0;
    end
    else if (stop_cond)
    begin
      next_st.stop_seen = 1'b1;
      next_st.start_seen = 1'b0;
      next_st.rw_flag = 1'b0;
      next_st.phase = ISSF_IDLE;
      next_st.hold_scl = 1'b0;
    end
    else
    begin
      case (st.phase)
        ISSF_RX:
        begin
          // Rises are counted, so the fall just after a start is no bit
          if (scl_rise)
          begin
            next_st.shift = {st.shift[6:0], st.sda_sync[1]};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end
          if (scl_fall)
          begin
            if (st.bit_cnt == `ISSF_ACK_BIT)
            begin
              next_st.phase = ISSF_RX_ACK;
              next_st.event_p = 1'b1;
              if (st.addr_phase)
              begin
                if (st.shift[7:1] == st.slave_addr)
                begin
                  next_st.addr_data_flag = 1'b0;
                  next_st.rw_flag = st.shift[0];
                  next_st.nack_out = 1'b0;
                  if (st.shift[0] && !st.read_stretch_en)
                    next_st.load_cnt = `ISSF_LOAD_DELAY;
                end
                else
                begin
                  next_st.nack_out = 1'b1;
                  next_st.phase = ISSF_SKIP;
                  next_st.event_p = 1'b0;
                end
              end
              else
              begin
                next_st.addr_data_flag = 1'b1;
                if (st.buf_full)
                begin
                  next_st.rx_overrun = 1'b1;
                  next_st.nack_out = 1'b1;
                end
                else
                begin
                  next_st.data_buffer = st.shift;
                  next_st.buf_full = 1'b1;
                  next_st.nack_out = 1'b0;
                end
              end
            end
          end
        end
        ISSF_RX_ACK, ISSF_TX_ACK:
        begin
          if (scl_rise)
          begin
            next_st.nack_flag = st.sda_sync[1];
            if (st.sda_sync[1] && st.phase == ISSF_TX_ACK)
              next_st.rw_flag = 1'b0;
          end
          if (scl_fall)
          begin
            next_st.addr_phase = 1'b0;
            next_st.bit_cnt = 4'h0;
            if (st.phase == ISSF_TX_ACK && st.nack_flag)
              next_st.phase = ISSF_IDLE;
            else if (st.rw_flag)
            begin
              next_st.phase = ISSF_TX;
              next_st.hold_scl = st.read_stretch_en;
            end
            else
              next_st.phase = ISSF_RX;
          end
        end
        ISSF_TX:
        begin
          if (scl_fall && !st.hold_scl)
          begin
            next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            if (st.bit_cnt == `ISSF_LAST_BIT)
            begin
              next_st.buf_full = 1'b0;
              next_st.addr_data_flag = 1'b1;
              next_st.phase = ISSF_TX_ACK;
              next_st.event_p = 1'b1;
              if (!st.read_stretch_en)
                next_st.load_cnt = `ISSF_LOAD_DELAY;
            end
          end
        end
        ISSF_SKIP: next_st.phase = ISSF_SKIP;
        default:   next_st.phase = ISSF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.scl_sync <= 2'h3;
      st.sda_sync <= 2'h3;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.phase <= ISSF_IDLE;
      st.slave_addr <= `ISSF_SLAVE_RST;
      st.stop_seen <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Drives only low, as open-drain pins must
  assign reg_rdata_o  = st.rdata;
  assign byte_event_o = st.event_p;
  assign scl_o        = 1'b0;
  assign scl_oe_o     = st.hold_scl;
  assign sda_o        = 1'b0;
  assign sda_oe_o     = (st.phase == ISSF_RX_ACK && !st.nack_out) ||
                        (st.phase == ISSF_TX && !st.hold_scl &&
                         !st.tx_shift[7]);
endmodule

//--- issf_regs.svh
// Constants of the I2C slave status and flag block.
// Assumes an 8-bit register port and an I2C bus sampled by the system clock.
`ifndef ISSF_REGS_SVH
`define ISSF_REGS_SVH
`define ISSF_ADDR_STATUS  2'h0
`define ISSF_ADDR_BUFFER  2'h1
`define ISSF_ADDR_CONTROL 2'h2
`define ISSF_ADDR_SLAVE   2'h3
`define ISSF_BIT_START    7
`define ISSF_BIT_STOP     6
`define ISSF_BIT_RW       5
`define ISSF_BIT_AD       4
`define ISSF_BIT_BF       3
`define ISSF_BIT_NACK     2
`define ISSF_BIT_WCOL     1
`define ISSF_BIT_ROVR     0
`define ISSF_CTL_RELEASE  0
`define ISSF_CTL_STRETCH  1
`define ISSF_LOAD_DELAY   2'h2
`define ISSF_LAST_BIT     4'h7
`define ISSF_ACK_BIT      4'h8
`define ISSF_SLAVE_RST    7'h2a
`endif

//--- issf_pkg.sv
// Types of the I2C slave status and flag block.
// Assumes the constants header is included by the users of this package.
package issf_pkg;
  typedef enum logic [2:0] {
    ISSF_IDLE,
    ISSF_RX,
    ISSF_RX_ACK,
    ISSF_TX,
    ISSF_TX_ACK,
    ISSF_SKIP
  } issf_phase_t;
endpackage

//--- issf_chk.sv
// Port checker of the I2C slave, bound to issf_slave.
// Assumes one clock domain and open-drain pins.
`include "issf_regs.svh"
module issf_chk
(
  // Slave ports
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       byte_event_o,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe_o,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o
);
  logic rel_wr;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  assign rel_wr = reg_wr_i && reg_addr_i == `ISSF_ADDR_CONTROL
                  && reg_wdata_i[`ISSF_CTL_RELEASE];
  sequence s_quiet;
    !byte_event_o [*8];
  endsequence
  sequence s_freed;
    ##[1:2] !scl_oe_o;
  endsequence
  property p_evt_gap;
    byte_event_o |=> s_quiet;
  endproperty
  property p_evt_low;
    byte_event_o |-> !scl_i;
  endproperty
  // SDA may only move while SCL is low, or a false start is seen
  property p_sda_edge;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  property p_scl_grab;
    $rose(scl_oe_o) |-> !scl_i;
  endproperty
  property p_scl_hold;
    $fell(scl_oe_o) |-> $past(rel_wr) || $past(rel_wr, 2);
  endproperty
  property p_scl_free;
    scl_oe_o && rel_wr |-> s_freed;
  endproperty
  property p_rd_hold;
    !$past(reg_rd_i) |-> $stable(reg_rdata_o);
  endproperty
  property p_od_low;
    !scl_o && !sda_o;
  endproperty
  a_evt_gap: assert property (p_evt_gap)
    else $error("byte events too close");
  a_evt_low: assert property (p_evt_low)
    else $error("byte event while SCL high");
  a_sda_edge: assert property (p_sda_edge)
    else $error("SDA moved with SCL high");
  a_scl_grab: assert property (p_scl_grab)
    else $error("stretch began with SCL high");
  a_scl_hold: assert property (p_scl_hold)
    else $error("stretch ended without release");
  a_scl_free: assert property (p_scl_free)
    else $error("release did not free SCL");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  a_od_low: assert property (p_od_low)
    else $error("open-drain pin driven high");
endmodule
bind issf_slave issf_chk issf_chk_inst (.clock_i, .rst_n_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .byte_event_o,
  .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o);

//--- issf_master.sv
// Behavioural I2C bus master for the slave port.
// Assumes the bench wires its open-drain drive with the slave's.
module issf_master
(
  // Wired bus levels
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Drive, 1 releases the line
  output logic      scl_m,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start_cond();
    #62.5 sda_m = 1'b0;
    #62.5 scl_m = 1'b0;
  endtask
  task automatic stop_cond();
    #20 sda_m = 1'b0;
    #62.5 scl_m = 1'b1;
    #62.5 sda_m = 1'b1;
    #62.5;
  endtask
  // SDA set 20 ns after the fall, so it never races SCL
  task automatic bit_cyc(input logic b, output logic s);
    int n;
    #20 sda_m = b;
    #42.5 scl_m = 1'b1;
    n = 0;
    while (!scl_w && n < 4000)
    begin
      #5 n++;
    end
    #62.5 s = sda_w;
    scl_m = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(tx[i], rx[i]);
    end
    bit_cyc(ack_in, ack_out);
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench of the I2C slave status and flag port.
// Assumes the master model and checker are compiled before it.
`include "issf_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] ST = `ISSF_ADDR_STATUS;
  localparam logic [1:0] BU = `ISSF_ADDR_BUFFER;
  localparam logic [1:0] CT = `ISSF_ADDR_CONTROL;
  logic       clock_i, rst_n_i, reg_wr_i, reg_rd_i, ack;
  logic [1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, rx;
  logic       byte_event_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic       scl_m, sda_m, scl_w, sda_w;
  int         bad_count = 0;
  int         n_tests = 0;
  int         n_events = 0;
  // Open drain: any party pulling low wins
  assign scl_w = scl_m & ~(scl_oe_o & ~scl_o);
  assign sda_w = sda_m & ~(sda_oe_o & ~sda_o);
  issf_slave issf_slave_inst (.clock_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .byte_event_o,
    .scl_i(scl_w), .scl_o, .scl_oe_o, .sda_i(sda_w), .sda_o, .sda_oe_o);
  issf_master issf_master_inst (.scl_w, .sda_w, .scl_m, .sda_m);
  // Byte events towards the CPU, counted for the closing check
  always @(posedge clock_i)
    if (byte_event_o === 1'b1)
      n_events <= n_events + 1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    rd(a);
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // Whole run is about 12 us of bus traffic
  initial
  begin
    #200us;
    bad_count++;
    finish_test();
  end
  initial
  begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 2'h0;
    reg_wdata_i = 8'h00;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk(ST, 8'h40);
    rd_chk(`ISSF_ADDR_SLAVE, 8'h2a);
    wr(ST, 8'hff);
    rd_chk(ST, 8'h40);
    wr(BU, 8'h77);
    rd_chk(ST, 8'h42);
    wr(ST, 8'hfd);
    rd_chk(ST, 8'h40);
    issf_master_inst.start_cond();
    issf_master_inst.xfer(8'h54, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
    rd_chk(BU, 8'h00);
    issf_master_inst.xfer(8'h5a, 1'b1, rx, ack);
    rd_chk(ST, 8'h98);
    rd_chk(BU, 8'h5a);
    rd_chk(ST, 8'h90);
    issf_master_inst.xfer(8'ha5, 1'b1, rx, ack);
    issf_master_inst.xfer(8'h3c, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h01);
    rd_chk(ST, 8'h9d);
    rd_chk(BU, 8'ha5);
    issf_master_inst.stop_cond();
    rd_chk(ST, 8'h55);
    wr(ST, 8'hfe);
    rd_chk(ST, 8'h54);
    wr(CT, 8'h02);
    issf_master_inst.start_cond();
    issf_master_inst.xfer(8'h55, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
    rd_chk(ST, 8'ha0);
    wr(BU, 8'hc3);
    rd_chk(ST, 8'ha8);
    fork
      issf_master_inst.xfer(8'hff, 1'b1, rx, ack);
      begin
        // Late release, so the master really meets a held clock
        #200;
        wr(CT, 8'h03);
        #300;
        wr(BU, 8'h11);
        rd_chk(ST, 8'haa);
      end
    join
    chk(rx, 8'hc3);
    rd_chk(ST, 8'h96);
    issf_master_inst.stop_cond();
    issf_master_inst.start_cond();
    issf_master_inst.xfer(8'h2a, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h01);
    issf_master_inst.stop_cond();
    // Read without stretch: the buffer is copied after the address event
    wr(CT, 8'h00);
    issf_master_inst.start_cond();
    issf_master_inst.xfer(8'h55, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
    issf_master_inst.xfer(8'hff, 1'b1, rx, ack);
    chk(rx, 8'hc3);
    issf_master_inst.stop_cond();
    chk(n_events[7:0], 8'h08);
    finish_test();
  end
endmodule
